// ### rtl/mcm_pkg.sv
// Operation
// - Encoder revolution count wraps after 1800 revolutions
// - Absolute position survives control supply loss
// - Coordinate parameters sampled only at power-on
// - Initial coordinate generated at every power-on
// - Factory span split evenly around home
// - Range in 0.1 rev, ratio in 0.01 %
// - Wrap presets present position back into range
// - Crossing range end continues from opposite end
// - Wrap on by default; off needs manual select
// - Step counter never preset by wrap events
// - Step counter readable through its own object
// - Step counter rolls over, never saturates
// - Coordinates-set output high once coordinates set
// - Unset coordinates block homing and gated absolute moves
// - Absolute permit: 0 disable, 1 enable, starts 0
// - Factory home fixed; flags factory-home output
// - Homing or preset sets user-home output
// - Preset clear removes user home
// - User home written to non-volatile memory sparingly
// - Preset loads both positions with home offset
// - Coordinates unset in factory state, homing, and clear when no factory home
// - Overflow output toggles on each wrap
package mcm_pkg;

  // Object indexes
  localparam logic [15:0] IDX_STEP_CNT = 16'h4091;
  localparam logic [15:0] IDX_ABS_PERMIT = 16'h4148;
  localparam logic [15:0] IDX_WRAP_EN = 16'h41C7;
  localparam logic [15:0] IDX_RANGE = 16'h41C9;
  localparam logic [15:0] IDX_RATIO = 16'h41CB;
  localparam logic [15:0] IDX_OFFSET = 16'h41CC;
  localparam logic [15:0] IDX_SRC_SEL = 16'h47F2;
  localparam logic [15:0] IDX_HOME_OFFSET = 16'h607C;

  // Reset values
  localparam logic [7:0] RST_ABS_PERMIT = 8'h00;
  localparam logic [7:0] RST_WRAP_EN = 8'h01;
  localparam logic [31:0] RST_RANGE = 32'h0000_4650;
  localparam logic [31:0] RST_RATIO = 32'h0000_1388;
  localparam logic [31:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [7:0] RST_SRC_SEL = 8'h00;
  localparam logic [31:0] RST_HOME_OFFSET = 32'h0000_0000;

  // Field encodings
  localparam logic [7:0] SEL_ENCODER = 8'h00;
  localparam logic [7:0] SEL_MANUAL = 8'h01;
  localparam logic [7:0] PERMIT_ENABLE = 8'h01;
  localparam logic [7:0] WRAP_DISABLE = 8'h00;

  // Scaling: range in tenths of a rev, ratio in hundredths of a percent
  localparam logic signed [63:0] RANGE_DIV = 64'sh0000_0000_0000_000A;
  localparam logic signed [63:0] RATIO_DIV = 64'sh0000_0000_0000_2710;
  // Revolutions the encoder can hold before its count restarts
  localparam logic signed [63:0] ENC_MAX_REV = 64'sh0000_0000_0000_0708;

  typedef enum logic [1:0] {
    MCM_WAIT = 2'b00,
    MCM_CALC = 2'b01,
    MCM_RUN = 2'b11
  } mcm_state_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic ovf;
  } mcm_wrap_st_t;

  typedef struct packed {
    mcm_state_t fsm;
    logic [31:0] step_cnt;
    logic [7:0] abs_permit;
    logic [7:0] wrap_en;
    logic [31:0] range;
    logic [31:0] ratio;
    logic [31:0] offset;
    logic [7:0] src_sel;
    logic [31:0] home_offset;
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic wrap_act;
    logic factory_home;
    logic user_home;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic reject;
    logic nvm_wr;
    logic nvm_home_set;
    logic [31:0] nvm_pos;
  } mcm_main_t;

endpackage

// ### rtl/mcm_wrap_pos.sv
`timescale 1ns/1ns
module mcm_wrap_pos (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Motion
  input wire logic step_i,
  input wire logic dir_i,
  // Preset
  input wire logic load_i,
  input wire logic signed [31:0] load_val_i,
  // Wrap window, lo inclusive, hi exclusive
  input wire logic wrap_en_i,
  input wire logic signed [31:0] lo_i,
  input wire logic signed [31:0] hi_i,
  // State
  output logic signed [31:0] pos_o,
  output logic ovf_o
);

  mcm_pkg::mcm_wrap_st_t st_r;
  mcm_pkg::mcm_wrap_st_t st_nxt;
  logic signed [31:0] top;

  always_comb begin
    st_nxt = st_r;
    top = hi_i - 32'sh0000_0001;
    if (load_i) begin
      st_nxt.pos = load_val_i;
    end else if (step_i) begin
      if (wrap_en_i && dir_i && st_r.pos >= top) begin
        st_nxt.pos = lo_i;
        st_nxt.ovf = ~st_r.ovf;
      end else if (wrap_en_i && !dir_i && st_r.pos <= lo_i) begin
        st_nxt.pos = top;
        st_nxt.ovf = ~st_r.ovf;
      end else if (dir_i) begin
        st_nxt.pos = st_r.pos + 32'sh0000_0001;
      end else begin
        st_nxt.pos = st_r.pos - 32'sh0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pos_o = st_r.pos;
  assign ovf_o = st_r.ovf;

endmodule

// ### rtl/mcm_coord_manager.sv
`timescale 1ns/1ns
module mcm_coord_manager #(
  parameter logic [31:0] STEPS_PER_REV = 32'h0000_03E8
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Object access from the controller
  input wire logic OBJ_REQ_I,
  input wire logic OBJ_WE_I,
  input wire logic [15:0] OBJ_INDEX_I,
  input wire logic [31:0] OBJ_WDATA_I,
  output logic [31:0] OBJ_RDATA_O,
  output logic OBJ_ACK_O,
  output logic OBJ_ERR_O,
  // Power-on inputs from encoder and configuration restore
  input wire logic CFG_DONE_I,
  input wire logic ENC_VALID_I,
  input wire logic [31:0] ENC_POS_I,
  input wire logic FACTORY_HOME_I,
  input wire logic USER_HOME_I,
  // Motion and home events
  input wire logic STEP_I,
  input wire logic DIR_I,
  input wire logic PRESET_I,
  input wire logic PRESET_CLR_I,
  input wire logic HOMING_I,
  input wire logic HOMING_DONE_I,
  // Operation requests
  input wire logic HS_HOME_REQ_I,
  input wire logic ABS_MOVE_REQ_I,
  output logic HS_HOME_GO_O,
  output logic ABS_MOVE_GO_O,
  output logic REJECT_O,
  // Status
  output logic [31:0] PRESENT_POS_O,
  output logic COORDS_SET_FLAG_O,
  output logic FACTORY_HOME_FLAG_O,
  output logic USER_HOME_FLAG_O,
  output logic WRAP_OVERFLOW_TOGGLE_O,
  output logic COORD_READY_O,
  // Non-volatile home store
  output logic NVM_WR_O,
  output logic NVM_HOME_SET_O,
  output logic [31:0] NVM_POS_O
);

  mcm_pkg::mcm_main_t st_r;
  mcm_pkg::mcm_main_t st_nxt;

  logic signed [63:0] spr;
  logic signed [63:0] span;
  logic signed [63:0] neg_part;
  logic signed [63:0] lo_w;
  logic signed [63:0] win;
  logic signed [63:0] rel;
  logic signed [63:0] pos0;
  logic [31:0] use_range;
  logic [31:0] use_ratio;
  logic [31:0] use_offset;
  logic use_wrap;
  logic coords_set;
  logic home_load;
  logic init_load;
  logic wrap_load;
  logic signed [31:0] load_val;
  logic signed [31:0] pos;
  logic ovf;

  // Encoder-priority mode uses the factory layout, even split about home
  always_comb begin
    if (st_r.src_sel == mcm_pkg::SEL_MANUAL) begin
      use_range = st_r.range;
      use_ratio = st_r.ratio;
      use_offset = st_r.offset;
      use_wrap = (st_r.wrap_en != mcm_pkg::WRAP_DISABLE);
    end else begin
      use_range = mcm_pkg::RST_RANGE;
      use_ratio = mcm_pkg::RST_RATIO;
      use_offset = mcm_pkg::RST_OFFSET;
      use_wrap = 1'b1;
    end
  end

  // Window arithmetic; wide on purpose so large ranges cannot overflow
  always_comb begin
    spr = $signed({32'h0000_0000, STEPS_PER_REV});
    span = ($signed({32'h0000_0000, use_range}) * spr)
      / mcm_pkg::RANGE_DIV;
    neg_part = ($signed({32'h0000_0000, use_ratio}) * span)
      / mcm_pkg::RATIO_DIV;
    lo_w = $signed({{32{use_offset[31]}}, use_offset}) - neg_part;
    // Without wrap, fold into the encoder's full revolution capacity
    if (use_wrap) begin
      win = span;
    end else begin
      win = mcm_pkg::ENC_MAX_REV * spr;
    end
    if (win <= 64'sh0) begin
      win = 64'sh1;
    end
    rel = ($signed({{32{ENC_POS_I[31]}}, ENC_POS_I}) - lo_w) % win;
    if (rel < 64'sh0) begin
      rel = rel + win;
    end
    pos0 = lo_w + rel;
  end

  // Coordinates count as set only with a home present and no homing running
  assign coords_set = (st_r.factory_home || st_r.user_home) && !HOMING_I
    && (st_r.fsm == mcm_pkg::MCM_RUN);

  assign home_load = (st_r.fsm == mcm_pkg::MCM_RUN)
    && (PRESET_I || HOMING_DONE_I);
  assign init_load = (st_r.fsm == mcm_pkg::MCM_CALC);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.reject = 1'b0;
    st_nxt.nvm_wr = 1'b0;

    case (st_r.fsm)
      mcm_pkg::MCM_WAIT: begin
        // Parameters are restored by the controller before generation
        if (CFG_DONE_I && ENC_VALID_I) begin
          st_nxt.fsm = mcm_pkg::MCM_CALC;
        end
      end
      mcm_pkg::MCM_CALC: begin
        // The only point where the generation parameters are taken
        st_nxt.lo = lo_w[31:0];
        st_nxt.hi = lo_w[31:0] + win[31:0];
        st_nxt.wrap_act = use_wrap;
        st_nxt.factory_home = FACTORY_HOME_I;
        st_nxt.user_home = USER_HOME_I;
        st_nxt.step_cnt = pos0[31:0];
        st_nxt.fsm = mcm_pkg::MCM_RUN;
      end
      mcm_pkg::MCM_RUN: begin
        if (home_load) begin
          st_nxt.step_cnt = st_r.home_offset;
        end else if (STEP_I) begin
          // Plain modular add, no wrap preset on this counter
          if (DIR_I) begin
            st_nxt.step_cnt = st_r.step_cnt + 32'h0000_0001;
          end else begin
            st_nxt.step_cnt = st_r.step_cnt - 32'h0000_0001;
          end
        end
        // A home set in the same cycle as a clear wins
        if (home_load) begin
          st_nxt.user_home = 1'b1;
          st_nxt.nvm_wr = 1'b1;
          st_nxt.nvm_home_set = 1'b1;
          st_nxt.nvm_pos = st_r.home_offset;
        end else if (PRESET_CLR_I && st_r.user_home) begin
          // Nothing is written when no user home exists, to spare the store
          st_nxt.user_home = 1'b0;
          st_nxt.nvm_wr = 1'b1;
          st_nxt.nvm_home_set = 1'b0;
          st_nxt.nvm_pos = 32'h0000_0000;
        end
        if (HS_HOME_REQ_I && !coords_set) begin
          st_nxt.reject = 1'b1;
        end
        if (ABS_MOVE_REQ_I && !coords_set
            && st_r.abs_permit != mcm_pkg::PERMIT_ENABLE) begin
          st_nxt.reject = 1'b1;
        end
      end
      default: begin
        st_nxt.fsm = mcm_pkg::MCM_WAIT;
      end
    endcase

    if (OBJ_REQ_I) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      case (OBJ_INDEX_I)
        mcm_pkg::IDX_STEP_CNT: begin
          st_nxt.rdata = st_r.step_cnt;
          st_nxt.err = OBJ_WE_I;
        end
        mcm_pkg::IDX_ABS_PERMIT: begin
          st_nxt.rdata = {24'h00_0000, st_r.abs_permit};
          if (OBJ_WE_I) begin
            // Only the two defined codes are accepted
            if (OBJ_WDATA_I[31:1] == 31'h0000_0000) begin
              st_nxt.abs_permit = OBJ_WDATA_I[7:0];
            end else begin
              st_nxt.err = 1'b1;
            end
          end
        end
        mcm_pkg::IDX_WRAP_EN: begin
          st_nxt.rdata = {24'h00_0000, st_r.wrap_en};
          if (OBJ_WE_I) begin
            st_nxt.wrap_en = OBJ_WDATA_I[7:0];
          end
        end
        mcm_pkg::IDX_RANGE: begin
          st_nxt.rdata = st_r.range;
          if (OBJ_WE_I) begin
            st_nxt.range = OBJ_WDATA_I;
          end
        end
        mcm_pkg::IDX_RATIO: begin
          st_nxt.rdata = st_r.ratio;
          if (OBJ_WE_I) begin
            st_nxt.ratio = OBJ_WDATA_I;
          end
        end
        mcm_pkg::IDX_OFFSET: begin
          st_nxt.rdata = st_r.offset;
          if (OBJ_WE_I) begin
            st_nxt.offset = OBJ_WDATA_I;
          end
        end
        mcm_pkg::IDX_SRC_SEL: begin
          st_nxt.rdata = {24'h00_0000, st_r.src_sel};
          if (OBJ_WE_I) begin
            st_nxt.src_sel = OBJ_WDATA_I[7:0];
          end
        end
        mcm_pkg::IDX_HOME_OFFSET: begin
          st_nxt.rdata = st_r.home_offset;
          if (OBJ_WE_I) begin
            st_nxt.home_offset = OBJ_WDATA_I;
          end
        end
        default: begin
          st_nxt.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      st_r <= '0;
      st_r.fsm <= mcm_pkg::MCM_WAIT;
      st_r.abs_permit <= mcm_pkg::RST_ABS_PERMIT;
      st_r.wrap_en <= mcm_pkg::RST_WRAP_EN;
      st_r.range <= mcm_pkg::RST_RANGE;
      st_r.ratio <= mcm_pkg::RST_RATIO;
      st_r.offset <= mcm_pkg::RST_OFFSET;
      st_r.src_sel <= mcm_pkg::RST_SRC_SEL;
      st_r.home_offset <= mcm_pkg::RST_HOME_OFFSET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Present position starts from the encoder, then follows motion
  assign wrap_load = init_load || home_load;
  assign load_val = init_load ? pos0[31:0] : st_r.home_offset;

  mcm_wrap_pos u_wrap (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .step_i(STEP_I && (st_r.fsm == mcm_pkg::MCM_RUN)),
    .dir_i(DIR_I),
    .load_i(wrap_load),
    .load_val_i(load_val),
    .wrap_en_i(st_r.wrap_act),
    .lo_i(st_r.lo),
    .hi_i(st_r.hi),
    .pos_o(pos),
    .ovf_o(ovf)
  );

  // Request gating is combinational so a granted move starts at once
  assign HS_HOME_GO_O = HS_HOME_REQ_I && coords_set;
  assign ABS_MOVE_GO_O = ABS_MOVE_REQ_I && (st_r.fsm == mcm_pkg::MCM_RUN)
    && (coords_set
    || st_r.abs_permit == mcm_pkg::PERMIT_ENABLE);

  assign OBJ_RDATA_O = st_r.rdata;
  assign OBJ_ACK_O = st_r.ack;
  assign OBJ_ERR_O = st_r.err;
  assign REJECT_O = st_r.reject;
  assign PRESENT_POS_O = pos;
  assign COORDS_SET_FLAG_O = coords_set;
  assign FACTORY_HOME_FLAG_O = st_r.factory_home;
  assign USER_HOME_FLAG_O = st_r.user_home;
  assign WRAP_OVERFLOW_TOGGLE_O = ovf;
  assign COORD_READY_O = (st_r.fsm == mcm_pkg::MCM_RUN);
  assign NVM_WR_O = st_r.nvm_wr;
  assign NVM_HOME_SET_O = st_r.nvm_home_set;
  assign NVM_POS_O = st_r.nvm_pos;

endmodule

// ### bench/mcm_chk_asserts.sv
`timescale 1ns/1ns
module mcm_chk #(parameter logic [31:0] STEPS_PER_REV = 32'h0000_03E8) (
  // Clock, reset and object bus
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic OBJ_REQ_I,
  input wire logic OBJ_WE_I,
  input wire logic [15:0] OBJ_INDEX_I,
  input wire logic OBJ_ACK_O,
  input wire logic OBJ_ERR_O,
  // Events and requests
  input wire logic STEP_I,
  input wire logic PRESET_I,
  input wire logic PRESET_CLR_I,
  input wire logic HOMING_I,
  input wire logic HS_HOME_REQ_I,
  input wire logic ABS_MOVE_REQ_I,
  input wire logic HS_HOME_GO_O,
  input wire logic ABS_MOVE_GO_O,
  input wire logic REJECT_O,
  // Status
  input wire logic COORDS_SET_FLAG_O,
  input wire logic FACTORY_HOME_FLAG_O,
  input wire logic USER_HOME_FLAG_O,
  input wire logic WRAP_OVERFLOW_TOGGLE_O,
  input wire logic COORD_READY_O,
  input wire logic NVM_WR_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_refused(logic go);
    !go ##1 REJECT_O;
  endsequence

  sequence s_home_kept;
    ##1 USER_HOME_FLAG_O && NVM_WR_O;
  endsequence

  chk_counter_ro: assert property (OBJ_REQ_I && OBJ_WE_I &&
    OBJ_INDEX_I == mcm_pkg::IDX_STEP_CNT |=> OBJ_ACK_O && OBJ_ERR_O)
    else $error("counter object accepted a write");
  chk_hs_unset: assert property (
    HS_HOME_REQ_I && !COORDS_SET_FLAG_O |-> s_refused(HS_HOME_GO_O))
    else $error("homing not refused while unset");
  chk_hs_grant: assert property (
    HS_HOME_REQ_I && COORDS_SET_FLAG_O |-> HS_HOME_GO_O)
    else $error("homing refused while set");
  chk_abs_grant: assert property (
    ABS_MOVE_REQ_I && COORDS_SET_FLAG_O |-> ABS_MOVE_GO_O)
    else $error("absolute move refused while set");
  chk_homing_unset: assert property (
    HOMING_I |-> !COORDS_SET_FLAG_O)
    else $error("coordinates set during homing");
  chk_coords_home: assert property (COORDS_SET_FLAG_O |->
    COORD_READY_O && (FACTORY_HOME_FLAG_O || USER_HOME_FLAG_O))
    else $error("coordinates set without a home");
  chk_preset_home: assert property (
    PRESET_I && COORD_READY_O |-> s_home_kept)
    else $error("preset did not store a user home");
  chk_clear_home: assert property (
    PRESET_CLR_I && !PRESET_I && COORD_READY_O |=> !USER_HOME_FLAG_O)
    else $error("preset clear kept the user home");
  chk_ovf_cause: assert property (
    $changed(WRAP_OVERFLOW_TOGGLE_O) |-> $past(STEP_I))
    else $error("overflow toggled without a step");
endmodule

bind mcm_coord_manager mcm_chk #(.STEPS_PER_REV(STEPS_PER_REV)) i_chk (
  .SYS_CLK_I, .RST_I, .OBJ_REQ_I, .OBJ_WE_I, .OBJ_INDEX_I, .OBJ_ACK_O,
  .OBJ_ERR_O, .STEP_I, .PRESET_I, .PRESET_CLR_I, .HOMING_I, .HS_HOME_REQ_I,
  .ABS_MOVE_REQ_I, .HS_HOME_GO_O, .ABS_MOVE_GO_O, .REJECT_O,
  .COORDS_SET_FLAG_O, .FACTORY_HOME_FLAG_O, .USER_HOME_FLAG_O,
  .WRAP_OVERFLOW_TOGGLE_O, .COORD_READY_O, .NVM_WR_O);

// ### bench/mcm_ctrl_model.sv
`timescale 1ns/1ns
module mcm_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Object bus
  output logic obj_req_o,
  output logic obj_we_o,
  output logic [15:0] obj_index_o,
  output logic [31:0] obj_wdata_o,
  input wire logic [31:0] obj_rdata_i,
  input wire logic obj_ack_i,
  input wire logic obj_err_i,
  // Power-on restore and encoder
  output logic cfg_done_o,
  output logic enc_valid_o,
  output logic [31:0] enc_pos_o,
  output logic factory_home_o,
  output logic user_home_o
);
  logic [31:0] enc_val = 32'h0000_0000;

  // An idle encoder bus must not look like a held position
  assign enc_pos_o = enc_valid_o ? enc_val : ~enc_val;

  initial begin
    obj_req_o = 1'h0;
    obj_we_o = 1'h0;
    obj_index_o = 16'h0000;
    obj_wdata_o = 32'h0000_0000;
    cfg_done_o = 1'h0;
    enc_valid_o = 1'h0;
    factory_home_o = 1'h0;
    user_home_o = 1'h0;
  end

  task automatic power_on(input logic [31:0] pos, input logic fh,
      input logic uh);
    @(posedge clk_i);
    #1;
    enc_val = pos;
    factory_home_o = fh;
    user_home_o = uh;
    enc_valid_o = 1'h1;
    cfg_done_o = 1'h1;
  endtask

  // Supply going down: restore and encoder are no longer valid
  task automatic power_off;
    @(posedge clk_i);
    #1;
    enc_valid_o = 1'h0;
    cfg_done_o = 1'h0;
  endtask

  // Request is a one-cycle pulse; answer awaited for four cycles
  task automatic access(input logic we, input logic [15:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic er,
      output logic to);
    to = 1'h1;
    rd = 32'h0000_0000;
    er = 1'h0;
    @(posedge clk_i);
    #1;
    obj_req_o = 1'h1;
    obj_we_o = we;
    obj_index_o = idx;
    obj_wdata_o = wd;
    @(posedge clk_i);
    #1;
    obj_req_o = 1'h0;
    obj_wdata_o = ~wd;
    for (int n = 0; n < 4 && to; n++) begin
      if (obj_ack_i === 1'h1) begin
        rd = obj_rdata_i;
        er = obj_err_i;
        to = 1'h0;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  // Ten steps a revolution keeps the manual wrap window a few steps wide
  localparam logic [31:0] SPR = 32'h0000_000A;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic step = 1'h0, dir = 1'h0, pre = 1'h0, clr = 1'h0, hom = 1'h0;
  logic homd = 1'h0, hsr = 1'h0, absr = 1'h0;
  logic req, we, ack, err, cfg, encv, fh, uh, hsg, absg, rej;
  logic cset, fhf, uhf, ovf, rdy, nvw, nvh;
  logic [15:0] idx;
  logic [31:0] wd, rd, encp, pos, nvp;
  int failures = 0;
  int checks = 0;

  always #2 clk = ~clk;

  mcm_ctrl_model i_ctrl (.clk_i(clk), .obj_req_o(req), .obj_we_o(we),
    .obj_index_o(idx), .obj_wdata_o(wd), .obj_rdata_i(rd), .obj_ack_i(ack),
    .obj_err_i(err), .cfg_done_o(cfg), .enc_valid_o(encv),
    .enc_pos_o(encp), .factory_home_o(fh), .user_home_o(uh));

  mcm_coord_manager #(.STEPS_PER_REV(SPR)) i_dut (.SYS_CLK_I(clk),
    .RST_I(rst), .OBJ_REQ_I(req), .OBJ_WE_I(we), .OBJ_INDEX_I(idx),
    .OBJ_WDATA_I(wd), .OBJ_RDATA_O(rd), .OBJ_ACK_O(ack), .OBJ_ERR_O(err),
    .CFG_DONE_I(cfg), .ENC_VALID_I(encv), .ENC_POS_I(encp),
    .FACTORY_HOME_I(fh), .USER_HOME_I(uh), .STEP_I(step), .DIR_I(dir),
    .PRESET_I(pre), .PRESET_CLR_I(clr), .HOMING_I(hom),
    .HOMING_DONE_I(homd), .HS_HOME_REQ_I(hsr), .ABS_MOVE_REQ_I(absr),
    .HS_HOME_GO_O(hsg), .ABS_MOVE_GO_O(absg), .REJECT_O(rej),
    .PRESENT_POS_O(pos), .COORDS_SET_FLAG_O(cset),
    .FACTORY_HOME_FLAG_O(fhf), .USER_HOME_FLAG_O(uhf),
    .WRAP_OVERFLOW_TOGGLE_O(ovf), .COORD_READY_O(rdy), .NVM_WR_O(nvw),
    .NVM_HOME_SET_O(nvh), .NVM_POS_O(nvp));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic obj(input logic w, input logic [15:0] i,
      input logic [31:0] d, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic er, to;
    i_ctrl.access(w, i, d, r, er, to);
    if (to) begin
      failures++;
      report_and_stop();
    end
    check({31'h0, er}, {31'h0, e});
    if (!w && !e) begin
      check(r, exp);
    end
  endtask

  task automatic ev(input logic p, input logic c, input logic hd,
      input logic s, input logic d);
    @(posedge clk);
    #1;
    pre = p;
    clr = c;
    homd = hd;
    step = s;
    dir = d;
    @(posedge clk);
    #1;
    pre = 1'h0;
    clr = 1'h0;
    homd = 1'h0;
    step = 1'h0;
  endtask

  task automatic try_req(input logic h, input logic go);
    @(posedge clk);
    #1;
    hsr = h;
    absr = !h;
    #1;
    check({31'h0, h ? hsg : absg}, {31'h0, go});
    @(posedge clk);
    #1;
    hsr = 1'h0;
    absr = 1'h0;
    check({31'h0, rej}, {31'h0, !go});
  endtask

  task automatic gen(input logic [31:0] p, input logic f);
    i_ctrl.power_on(p, f, 1'h0);
    for (int n = 0; n < 8 && rdy !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    check({31'h0, rdy}, 32'h1);
    if (rdy !== 1'h1) begin
      report_and_stop();
    end
  endtask

  // Control power cycle in mid-run; generation must start over
  task automatic reboot;
    i_ctrl.power_off();
    @(posedge clk);
    #1;
    rst = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'h0;
    check({31'h0, rdy}, 32'h0);
  endtask

  task automatic t_reset_values;
    obj(1'h0, mcm_pkg::IDX_ABS_PERMIT, 0, 32'h0, 1'h0);
    obj(1'h0, mcm_pkg::IDX_WRAP_EN, 0, 32'h1, 1'h0);
    obj(1'h0, mcm_pkg::IDX_RANGE, 0, 32'h4650, 1'h0);
    obj(1'h0, mcm_pkg::IDX_RATIO, 0, 32'h1388, 1'h0);
    obj(1'h0, mcm_pkg::IDX_OFFSET, 0, 32'h0, 1'h0);
    obj(1'h0, mcm_pkg::IDX_SRC_SEL, 0, 32'h0, 1'h0);
    obj(1'h0, 16'h1234, 0, 32'h0, 1'h1);
    obj(1'h1, mcm_pkg::IDX_STEP_CNT, 32'h5, 0, 1'h1);
    obj(1'h1, mcm_pkg::IDX_ABS_PERMIT, 32'h2, 0, 1'h1);
  endtask

  // Window of one revolution centred on home: -5 up to 4
  task automatic t_generate;
    obj(1'h1, mcm_pkg::IDX_SRC_SEL, 32'h1, 0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_RANGE, 32'hA, 0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_RATIO, 32'h1388, 0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_OFFSET, 32'h0, 0, 1'h0);
    gen(32'h3, 1'h0);
    check(pos, 32'h3);
    check({31'h0, cset}, 32'h0);
    obj(1'h0, mcm_pkg::IDX_STEP_CNT, 0, 32'h3, 1'h0);
    obj(1'h1, mcm_pkg::IDX_RANGE, 32'h14, 0, 1'h0);
  endtask

  task automatic t_unset;
    try_req(1'h1, 1'h0);
    try_req(1'h0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_ABS_PERMIT, 32'h1, 0, 1'h0);
    try_req(1'h0, 1'h1);
  endtask

  task automatic t_wrap;
    ev(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    check(pos, 32'h4);
    ev(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    check(pos, 32'hFFFF_FFFB);
    check({31'h0, ovf}, 32'h1);
    obj(1'h0, mcm_pkg::IDX_STEP_CNT, 0, 32'h5, 1'h0);
    ev(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    check(pos, 32'h4);
    check({31'h0, ovf}, 32'h0);
    obj(1'h0, mcm_pkg::IDX_STEP_CNT, 0, 32'h4, 1'h0);
  endtask

  task automatic t_home;
    obj(1'h1, mcm_pkg::IDX_HOME_OFFSET, 32'h2, 0, 1'h0);
    ev(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    check(pos, 32'h2);
    check({28'h0, nvw, nvh, uhf, cset}, 32'hF);
    check(nvp, 32'h2);
    obj(1'h0, mcm_pkg::IDX_STEP_CNT, 0, 32'h2, 1'h0);
    try_req(1'h1, 1'h1);
    ev(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    check({30'h0, uhf, cset}, 32'h0);
    hom = 1'h1;
    ev(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    check({30'h0, uhf, cset}, 32'h2);
    hom = 1'h0;
    #1;
    check({31'h0, cset}, 32'h1);
  endtask

  task automatic t_roll;
    obj(1'h1, mcm_pkg::IDX_HOME_OFFSET, 32'h7FFF_FFFF, 0, 1'h0);
    ev(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    ev(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    obj(1'h0, mcm_pkg::IDX_STEP_CNT, 0, 32'h8000_0000, 1'h0);
  endtask

  // Wrap off: folded into the full encoder span, -5 up to 17994
  task automatic t_nowrap;
    reboot();
    obj(1'h1, mcm_pkg::IDX_SRC_SEL, 32'h1, 0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_WRAP_EN, 32'h0, 0, 1'h0);
    obj(1'h1, mcm_pkg::IDX_RANGE, 32'hA, 0, 1'h0);
    gen(32'h4654, 1'h0);
    check(pos, 32'h4);
    ev(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    check(pos, 32'h5);
    check({31'h0, ovf}, 32'h0);
  endtask

  // Factory layout around a factory home: -9000 up to 8999
  task automatic t_factory;
    reboot();
    obj(1'h0, mcm_pkg::IDX_SRC_SEL, 0, 32'h0, 1'h0);
    gen(32'h232D, 1'h1);
    check(pos, 32'hFFFF_DCDD);
    check({30'h0, fhf, cset}, 32'h3);
    try_req(1'h1, 1'h1);
    try_req(1'h0, 1'h1);
    ev(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    check({29'h0, nvw, fhf, cset}, 32'h3);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'h0;
    t_reset_values();
    t_generate();
    t_unset();
    t_wrap();
    t_home();
    t_roll();
    t_nowrap();
    t_factory();
    report_and_stop();
  end
endmodule
